/* File: verilog/rtcis_map.svh */
// constants for the two-wire rtc slave port and its bus master
// assumes: included by bare name wherever a constant is needed
`ifndef RTCIS_MAP_SVH
`define RTCIS_MAP_SVH

// slave address bytes, direction bit included
`define RTCIS_ADDR_RD   8'ha3
`define RTCIS_ADDR_WR   8'ha2

// register pointer width, index of the last bit of a byte, and the ack slot
`define RTCIS_PTR_W     4
`define RTCIS_LAST_BIT  3'h7
`define RTCIS_ACK_SLOT  4'h8

// master clock rate and the serial clock rate it makes, in kHz
`define RTCIS_SYS_KHZ   20000
`define RTCIS_SCL_KHZ   400
// cycles per quarter of a serial bit; rounded up so the bus never runs fast
`define RTCIS_QTR_CYC   ((`RTCIS_SYS_KHZ + 4 * `RTCIS_SCL_KHZ - 1) / (4 * `RTCIS_SCL_KHZ))

`endif

/* File: verilog/rtcis_pkg.sv */
// types shared by both ends of the two-wire rtc slave port
// assumes: constants come from rtcis_map.svh
package rtcis_pkg;

    // slave states, gray along idle-address-ack-write and ack-read paths
    typedef enum logic [2:0] {
        RTCIS_ST_IDLE  = 3'h0,
        RTCIS_ST_ADDR  = 3'h1,
        RTCIS_ST_AACK  = 3'h3,
        RTCIS_ST_WDATA = 3'h2,
        RTCIS_ST_WACK  = 3'h6,
        RTCIS_ST_RDATA = 3'h7,
        RTCIS_ST_RACK  = 3'h5,
        RTCIS_ST_SKIP  = 3'h4
    } rtcis_dev_state_type;

    // master command codes
    typedef enum logic [1:0] {
        RTCIS_OP_START = 2'h0,
        RTCIS_OP_WRITE = 2'h1,
        RTCIS_OP_READ  = 2'h3,
        RTCIS_OP_STOP  = 2'h2
    } rtcis_op_type;

    typedef enum logic {
        RTCIS_H_IDLE = 1'b0,
        RTCIS_H_BUSY = 1'b1
    } rtcis_hst_type;

endpackage

/* File: verilog/rtcis_if.sv */
// wires of the two-wire bus between master and rtc slave
// assumes: both lines are pulled high when nobody drives them
`timescale 1ns/100ps
`default_nettype none
interface rtcis_if;
    logic m_scl_out;   // master clock level when driving
    logic m_scl_oe_n;  // master drives clock when low
    logic m_sda_out;   // master data level when driving
    logic m_sda_oe_n;  // master drives data when low
    logic d_sda_out;   // slave data level when driving
    logic d_sda_oe_n;  // slave drives data when low
    logic scl;         // resolved clock line
    logic sda;         // resolved data line

    // wired-and with pull-ups
    assign scl = m_scl_oe_n ? 1'b1 : m_scl_out;
    assign sda = (m_sda_oe_n ? 1'b1 : m_sda_out) & (d_sda_oe_n ? 1'b1 : d_sda_out);

    modport dev  (input scl, input sda, output d_sda_out, output d_sda_oe_n);
    modport host (input scl, input sda, output m_scl_out, output m_scl_oe_n,
                  output m_sda_out, output m_sda_oe_n);
endinterface
`default_nettype wire

/* File: verilog/rtcis_host.sv */
// bus master end: byte-level commands in, serial clock and data out
// assumes: one slave that never stretches the clock; sys_clk at 20 MHz
`timescale 1ns/100ps
`default_nettype none
`include "rtcis_map.svh"
module rtcis_host
#(
    parameter int unsigned QTR = `RTCIS_QTR_CYC  // cycles per quarter bit
)
(
    input  wire logic                  sys_clk,    // master clock
    input  wire logic                  rst_n,      // sync reset
    rtcis_if.host                      bus,        // two-wire bus
    input  wire logic                  cmd_valid,  // command offered
    output var logic                   cmd_ready,  // command may be taken
    input  wire rtcis_pkg::rtcis_op_type cmd_op,   // start, write, read, stop
    input  wire logic [7:0]            cmd_data,   // byte to write
    input  wire logic                  cmd_last,   // read: withhold ack
    output var logic                   rsp_valid,  // byte op finished, pulse
    output var logic [7:0]             rsp_data,   // byte read
    output var logic                   rsp_nack    // ack bit seen on the bus
);
    import rtcis_pkg::*;

    rtcis_hst_type st_q;
    rtcis_op_type  op_q;
    logic [7:0]    div_q;
    logic [1:0]    qtr_q;
    logic [3:0]    bit_q;
    logic [7:0]    sh_q;
    logic [7:0]    rx_q;
    logic          last_q;
    logic          scl_q;
    logic          sda_q;
    logic          sda_s1_q;
    logic          sda_s2_q;

    wire tick_w    = (st_q == RTCIS_H_BUSY) && (div_q == 8'(QTR - 1));
    wire ack_bit_w = (bit_q == `RTCIS_ACK_SLOT);
    wire is_wr_w   = (op_q == RTCIS_OP_WRITE);
    wire is_byte_w = is_wr_w || (op_q == RTCIS_OP_READ);
    // level put on data for the current slot; 1 means released
    wire wr_lvl_w  = ack_bit_w ? 1'b1 : sh_q[7];
    wire rd_lvl_w  = ack_bit_w ? last_q : 1'b1;  // see (RL3) see (RL5)
    wire done_w    = tick_w && (qtr_q == 2'h3) && (!is_byte_w || ack_bit_w);

    assign bus.m_scl_out  = scl_q;
    assign bus.m_scl_oe_n = scl_q;
    assign bus.m_sda_out  = sda_q;
    assign bus.m_sda_oe_n = sda_q;

    always_ff @(posedge sys_clk)
    begin
        sda_s1_q <= bus.sda;
        sda_s2_q <= sda_s1_q;
    end

    always_ff @(posedge sys_clk)
    begin
        if (!rst_n || st_q == RTCIS_H_IDLE || tick_w)
            div_q <= 8'h0;
        else
            div_q <= div_q + 8'h1;
    end

    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
        begin
            st_q      <= RTCIS_H_IDLE;
            op_q      <= RTCIS_OP_STOP;
            qtr_q     <= 2'h0;
            bit_q     <= 4'h0;
            sh_q      <= 8'h0;
            rx_q      <= 8'h0;
            last_q    <= 1'b0;
            scl_q     <= 1'b1;
            sda_q     <= 1'b1;
            cmd_ready <= 1'b0;
            rsp_valid <= 1'b0;
            rsp_data  <= 8'h0;
            rsp_nack  <= 1'b0;
        end
        else
        begin
            rsp_valid <= done_w && is_byte_w;
            if (st_q == RTCIS_H_IDLE)
            begin
                cmd_ready <= 1'b1;
                if (cmd_valid && cmd_ready)
                begin
                    st_q      <= RTCIS_H_BUSY;
                    cmd_ready <= 1'b0;
                    op_q      <= cmd_op;
                    sh_q      <= cmd_data;
                    last_q    <= cmd_last;
                    qtr_q     <= 2'h0;
                    bit_q     <= 4'h0;
                end
            end
            else if (tick_w)
            begin
                qtr_q <= qtr_q + 2'h1;
                case (qtr_q)
                    // slot data moves only while the clock is low; start and stop move it while high
                    2'h0:
                        case (op_q)
                            RTCIS_OP_START: sda_q <= 1'b1;
                            RTCIS_OP_STOP:  sda_q <= 1'b0;
                            RTCIS_OP_WRITE: sda_q <= wr_lvl_w;  // see (RL16)
                            default:        sda_q <= rd_lvl_w;  // see (RL4)
                        endcase
                    2'h1:
                        scl_q <= 1'b1;
                    2'h2:
                        if (op_q == RTCIS_OP_START)
                            sda_q <= 1'b0;  // see (RL14)
                        else if (op_q == RTCIS_OP_STOP)
                            sda_q <= 1'b1;  // see (RL15)
                        else if (ack_bit_w)
                            rsp_nack <= sda_s2_q;
                        else
                            rx_q <= {rx_q[6:0], sda_s2_q};
                    default:
                    begin
                        if (op_q != RTCIS_OP_STOP)
                            scl_q <= 1'b0;
                        if (done_w)
                        begin
                            st_q     <= RTCIS_H_IDLE;
                            rsp_data <= rx_q;
                        end
                        else
                        begin
                            bit_q <= bit_q + 4'h1;  // see (RL1)
                            sh_q  <= {sh_q[6:0], 1'b0};
                        end
                    end
                endcase
            end
        end
    end
endmodule
`default_nettype wire

/* File: verilog/rtcis_dev.sv */
// slave end of the rtc two-wire port: address match, register pointer,
// byte receive and transmit with acknowledge, register store
// assumes: link_clk is a free-running sampling clock several times faster
// than the serial clock; sys_clk side only watches register writes
//
// What this block does
// (RL1) any byte count; ninth clock acknowledges
// (RL2) slave acks every received byte incl. a matching address
// (RL3) master acks each read byte but last
// (RL4) acker holds data low through clock high
// (RL5) master ends read by withholding ack
// (RL6) after nack, slave releases data, sends nothing
// (RL7) first byte after start is the address
// (RL8) never drive clock; data only ack/transmit
// (RL9) a3 reads, a2 writes
// (RL10) first written byte sets four-bit pointer
// (RL11) addressed read: write pointer, then read
// (RL12) read address: transmit from pointer at once
// (RL13) reset clears pointer, slave stays off bus
// (RL14) data falling, clock high means start
// (RL15) data rising, clock high means stop
// (RL16) data changes only while clock low
// (RL17) pointer advances after each data byte
// (RL18) unmatched address: stay released until start
`timescale 1ns/100ps
`default_nettype none
`include "rtcis_map.svh"
module rtcis_dev
(
    input  wire logic                    sys_clk,   // user-side clock
    input  wire logic                    rst_n,     // sync reset, sys_clk
    input  wire logic                    link_clk,  // sampling clock of the link
    rtcis_if.dev                         bus,       // two-wire bus
    output var logic                     wr_stb,    // register written, pulse
    output var logic [`RTCIS_PTR_W-1:0]  wr_addr,   // register written
    output var logic [7:0]               wr_data    // value written
);
    import rtcis_pkg::*;

    localparam int unsigned NREG = 1 << `RTCIS_PTR_W;

    // reset carried into the link domain
    logic                    lrst_s1_q;
    logic                    lrst_n_q;
    // line synchronisers and one stage of history for edges
    logic                    scl_s1_q;
    logic                    scl_s2_q;
    logic                    scl_s3_q;
    logic                    sda_s1_q;
    logic                    sda_s2_q;
    logic                    sda_s3_q;

    rtcis_dev_state_type     st_q;
    logic [2:0]              cnt_q;
    logic [7:0]              sh_q;
    logic [7:0]              tx_q;
    logic [`RTCIS_PTR_W-1:0] ptr_q;
    logic                    ph_q;
    logic                    rd_q;
    logic                    idx_q;
    logic                    drv_q;
    logic [7:0]              regs [NREG];

    // write event handed to sys_clk; hold values stay put until the next write
    logic                    wtog_q;
    logic [`RTCIS_PTR_W-1:0] hold_addr_q;
    logic [7:0]              hold_data_q;
    logic                    wt_s1_q;
    logic                    wt_s2_q;
    logic                    wt_s3_q;

    wire       scl_hi_w  = scl_s2_q && scl_s3_q;
    wire       start_w   = scl_hi_w && sda_s3_q && !sda_s2_q;  // see (RL14)
    wire       stop_w    = scl_hi_w && !sda_s3_q && sda_s2_q;  // see (RL15)
    wire       rise_w    = !scl_s3_q && scl_s2_q;
    wire       fall_w    = scl_s3_q && !scl_s2_q;
    wire [7:0] byte_w    = {sh_q[6:0], sda_s2_q};
    wire       last_w    = rise_w && (cnt_q == `RTCIS_LAST_BIT);  // see (RL1)
    wire       is_rd_w   = (byte_w == `RTCIS_ADDR_RD);  // see (RL9)
    wire       is_wr_w   = (byte_w == `RTCIS_ADDR_WR);  // see (RL9)
    wire       quiet_w   = !start_w && !stop_w;
    wire       reg_we_w  = quiet_w && (st_q == RTCIS_ST_WDATA) && last_w && !idx_q;
    wire [7:0] rd_byte_w = regs[ptr_q];
    wire       wt_evt_w  = wt_s2_q ^ wt_s3_q;

    // open drain: the data line is only ever pulled low; clock is never driven
    assign bus.d_sda_out  = drv_q;  // see (RL8)
    assign bus.d_sda_oe_n = drv_q;

    always_ff @(posedge link_clk)
    begin
        lrst_s1_q <= rst_n;
        lrst_n_q  <= lrst_s1_q;
        scl_s1_q  <= bus.scl;
        scl_s2_q  <= scl_s1_q;
        scl_s3_q  <= scl_s2_q;
        sda_s1_q  <= bus.sda;
        sda_s2_q  <= sda_s1_q;
        sda_s3_q  <= sda_s2_q;
    end

    for (genvar i = 0; i < NREG; i++)
    begin : g_reg
        always_ff @(posedge link_clk)
        begin
            if (!lrst_n_q)
                regs[i] <= 8'h0;
            else if (reg_we_w && ptr_q == `RTCIS_PTR_W'(i))
                regs[i] <= byte_w;
        end
    end

    always_ff @(posedge link_clk)
    begin
        if (!lrst_n_q)
        begin
            // pointer and bus logic start over; line stays released
            st_q  <= RTCIS_ST_IDLE;  // see (RL13)
            cnt_q <= 3'h0;
            sh_q  <= 8'h0;
            tx_q  <= 8'h0;
            ptr_q <= '0;
            ph_q  <= 1'b0;
            rd_q  <= 1'b0;
            idx_q <= 1'b0;
            drv_q <= 1'b1;
        end
        else if (start_w)
        begin
            // a start, repeated or not, always re-arms address matching
            st_q  <= RTCIS_ST_ADDR;  // see (RL7)
            cnt_q <= 3'h0;
            ph_q  <= 1'b0;
            drv_q <= 1'b1;
        end
        else if (stop_w)
        begin
            st_q  <= RTCIS_ST_IDLE;
            drv_q <= 1'b1;
        end
        else
        begin
            case (st_q)
                RTCIS_ST_ADDR, RTCIS_ST_WDATA:
                    if (rise_w)
                    begin
                        sh_q  <= byte_w;
                        cnt_q <= cnt_q + 3'h1;
                        if (last_w && st_q == RTCIS_ST_ADDR)
                        begin
                            rd_q  <= is_rd_w;
                            idx_q <= 1'b1;
                            if (is_rd_w || is_wr_w)
                                st_q <= RTCIS_ST_AACK;  // see (RL7)
                            else
                                st_q <= RTCIS_ST_SKIP;  // see (RL18)
                        end
                        else if (last_w)
                        begin
                            st_q  <= RTCIS_ST_WACK;
                            idx_q <= 1'b0;
                            if (idx_q)
                                ptr_q <= byte_w[`RTCIS_PTR_W-1:0];  // see (RL10) see (RL11)
                            else
                                ptr_q <= ptr_q + 1'b1;  // see (RL17)
                        end
                    end
                RTCIS_ST_AACK, RTCIS_ST_WACK:
                    if (fall_w && !ph_q)
                    begin
                        drv_q <= 1'b0;  // see (RL2) see (RL4)
                        ph_q  <= 1'b1;
                    end
                    else if (fall_w)
                    begin
                        ph_q  <= 1'b0;
                        cnt_q <= 3'h0;
                        if (st_q == RTCIS_ST_AACK && rd_q)
                        begin
                            // first read byte goes out right after the ack
                            st_q  <= RTCIS_ST_RDATA;  // see (RL12)
                            drv_q <= rd_byte_w[7];
                            tx_q  <= {rd_byte_w[6:0], 1'b0};
                            ptr_q <= ptr_q + 1'b1;  // see (RL17)
                        end
                        else
                        begin
                            st_q  <= RTCIS_ST_WDATA;
                            drv_q <= 1'b1;
                        end
                    end
                RTCIS_ST_RDATA:
                    if (rise_w)
                    begin
                        cnt_q <= cnt_q + 3'h1;
                        if (last_w)
                            st_q <= RTCIS_ST_RACK;
                    end
                    else if (fall_w)
                    begin
                        drv_q <= tx_q[7];  // see (RL16)
                        tx_q  <= {tx_q[6:0], 1'b0};
                    end
                RTCIS_ST_RACK:
                    if (fall_w && !ph_q)
                    begin
                        drv_q <= 1'b1;
                        ph_q  <= 1'b1;
                    end
                    else if (rise_w && sda_s2_q)
                        st_q <= RTCIS_ST_SKIP;  // see (RL6) see (RL5)
                    else if (fall_w)
                    begin
                        // master acked: keep streaming from the pointer
                        st_q  <= RTCIS_ST_RDATA;  // see (RL3)
                        ph_q  <= 1'b0;
                        cnt_q <= 3'h0;
                        drv_q <= rd_byte_w[7];
                        tx_q  <= {rd_byte_w[6:0], 1'b0};
                        ptr_q <= ptr_q + 1'b1;  // see (RL17)
                    end
                default:
                    drv_q <= 1'b1;  // see (RL18)
            endcase
        end
    end

    always_ff @(posedge link_clk)
    begin
        if (!lrst_n_q)
        begin
            wtog_q      <= 1'b0;
            hold_addr_q <= '0;
            hold_data_q <= 8'h0;
        end
        else if (reg_we_w)
        begin
            wtog_q      <= !wtog_q;
            hold_addr_q <= ptr_q;
            hold_data_q <= byte_w;
        end
    end

    // writes are at least nine serial clocks apart, so the toggle never laps
    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
        begin
            wt_s1_q <= 1'b0;
            wt_s2_q <= 1'b0;
            wt_s3_q <= 1'b0;
            wr_stb  <= 1'b0;
            wr_addr <= '0;
            wr_data <= 8'h0;
        end
        else
        begin
            wt_s1_q <= wtog_q;
            wt_s2_q <= wt_s1_q;
            wt_s3_q <= wt_s2_q;
            wr_stb  <= wt_evt_w;
            if (wt_evt_w)
            begin
                wr_addr <= hold_addr_q;
                wr_data <= hold_data_q;
            end
        end
    end
endmodule
`default_nettype wire

/* File: verif/rtcis_chk.sv */
// checker for the two-wire bus between master and rtc slave
// assumes: sampled on sys_clk, which is many times faster than the serial clock
`timescale 1ns/100ps
`default_nettype none
`include "rtcis_map.svh"
module rtcis_chk
(
    input  wire logic sys_clk,     // master clock
    input  wire logic rst_n,       // sync reset
    input  wire logic scl,         // resolved clock line
    input  wire logic sda,         // resolved data line
    input  wire logic m_scl_out,   // master clock level
    input  wire logic m_scl_oe_n,  // master clock enable
    input  wire logic m_sda_out,   // master data level
    input  wire logic m_sda_oe_n,  // master data enable
    input  wire logic d_sda_out,   // slave data level
    input  wire logic d_sda_oe_n   // slave data enable
);
    localparam logic [1:0] MD_NONE = 2'h0;
    localparam logic [1:0] MD_WR   = 2'h1;
    localparam logic [1:0] MD_RD   = 2'h2;
    logic       scl_q, sda_q, first_q, first_d;
    logic [3:0] bit_q, bit_d;
    logic [7:0] byte_q, byte_d;
    logic [1:0] mode_q, mode_d;
    wire start_w = scl & scl_q & sda_q & ~sda;
    wire stop_w  = scl & scl_q & ~sda_q & sda;
    wire rise_w  = scl & ~scl_q;
    wire ack_w   = rise_w & (bit_q == `RTCIS_ACK_SLOT);
    wire rd_w    = (byte_q == `RTCIS_ADDR_RD);
    wire match_w = rd_w | (byte_q == `RTCIS_ADDR_WR);
    // a nack on a read byte ends the slave's part just like a stop
    assign mode_d  = (start_w | stop_w) ? MD_NONE :
                     (ack_w & first_q & match_w) ? (rd_w ? MD_RD : MD_WR) :
                     (ack_w & (mode_q == MD_RD) & sda) ? MD_NONE : mode_q;
    assign bit_d   = start_w ? 4'h0 : rise_w ? (ack_w ? 4'h0 : bit_q + 4'h1) : bit_q;
    assign byte_d  = (rise_w & ~ack_w) ? {byte_q[6:0], sda} : byte_q;
    assign first_d = start_w ? 1'b1 : ack_w ? 1'b0 : first_q;
    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
            {scl_q, sda_q, first_q, bit_q, byte_q, mode_q} <= {3'h6, 4'h0, 8'h00, MD_NONE};
        else
            {scl_q, sda_q, first_q, bit_q, byte_q, mode_q} <=
                {scl, sda, first_d, bit_d, byte_d, mode_d};
    end
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!rst_n);
    // outside a read the slave may only pull data low for an acknowledge
    dev_open_drain_a: assert property
        (rise_w && !d_sda_oe_n && mode_q != MD_RD |-> ack_w && !d_sda_out)
        else $error("slave drives data outside an acknowledge");
    // only start and stop may move the master's data while the clock is high
    host_stable_a: assert property
        (scl && $past(scl) && !start_w && !stop_w |->
            $stable(m_sda_oe_n) && (m_sda_oe_n || !m_sda_out) && (m_scl_oe_n || !m_scl_out))
        else $error("master changes data while clock high");
    dev_stable_a: assert property (scl && $past(scl) |-> $stable(d_sda_oe_n))
        else $error("slave changes data while clock high");
    addr_ack_a: assert property (ack_w && first_q |-> (sda == !match_w))
        else $error("address acknowledge wrong");
    data_ack_a: assert property (ack_w && !first_q && mode_q == MD_WR |-> !sda)
        else $error("written byte not acknowledged");
    ack_hold_a: assert property (ack_w && !sda |-> (!sda) [*8])
        else $error("acknowledge not held through clock high");
    rd_release_a: assert property (ack_w && mode_q == MD_RD |-> d_sda_oe_n)
        else $error("slave drives data in master acknowledge slot");
    silent_a: assert property (mode_q == MD_NONE && !first_q |-> d_sda_oe_n)
        else $error("slave drives data while not addressed");
    cover property (ack_w && first_q && rd_w);
    cover property (ack_w && !first_q && mode_q == MD_WR);
    cover property (ack_w && mode_q == MD_RD && sda);
    cover property (ack_w && first_q && !match_w);
endmodule
`default_nettype wire

/* File: verif/rtcis_tb.sv */
// testbench: master commands in, slave register writes out, over one bus
// assumes: host quarter bit shortened to 8 cycles, link clock 48 ns
`timescale 1ns/100ps
`default_nettype none
`include "rtcis_map.svh"
module tb;
    import rtcis_pkg::*;
    localparam int unsigned QTR = 8;
    logic                    sys_clk   = 1'b0;
    logic                    link_clk  = 1'b0;
    logic                    rst_n     = 1'b0;
    logic                    cmd_valid = 1'b0;
    rtcis_op_type            cmd_op    = RTCIS_OP_START;
    logic [7:0]              cmd_data  = 8'h00;
    logic                    cmd_last  = 1'b0;
    logic                    cmd_ready, rsp_valid, rsp_nack, wr_stb, nk_v;
    logic [7:0]              rsp_data, wr_data, rd_v;
    logic [`RTCIS_PTR_W-1:0] wr_addr;
    logic [11:0]             wq[$];
    logic [7:0]              bad[3] = '{8'ha0, 8'ha6, 8'h22};
    int                      fail_count = 0;
    int                      samples_checked = 0;
    always #25 sys_clk = ~sys_clk;
    always #24 link_clk = ~link_clk;
    rtcis_if rtcis_if_inst ();
    rtcis_host #(.QTR(QTR)) rtcis_host_inst (.sys_clk(sys_clk), .rst_n(rst_n),
        .bus(rtcis_if_inst), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_op(cmd_op),
        .cmd_data(cmd_data), .cmd_last(cmd_last), .rsp_valid(rsp_valid),
        .rsp_data(rsp_data), .rsp_nack(rsp_nack));
    rtcis_dev rtcis_dev_inst (.sys_clk(sys_clk), .rst_n(rst_n), .link_clk(link_clk),
        .bus(rtcis_if_inst), .wr_stb(wr_stb), .wr_addr(wr_addr), .wr_data(wr_data));
    rtcis_chk rtcis_chk_inst (.sys_clk(sys_clk), .rst_n(rst_n), .scl(rtcis_if_inst.scl),
        .sda(rtcis_if_inst.sda), .m_scl_out(rtcis_if_inst.m_scl_out),
        .m_scl_oe_n(rtcis_if_inst.m_scl_oe_n), .m_sda_out(rtcis_if_inst.m_sda_out),
        .m_sda_oe_n(rtcis_if_inst.m_sda_oe_n), .d_sda_out(rtcis_if_inst.d_sda_out),
        .d_sda_oe_n(rtcis_if_inst.d_sda_oe_n));
    // strobe is sampled mid-cycle, well away from the edge that launches it
    always @(negedge sys_clk)
        if (wr_stb === 1'b1)
            wq.push_back({wr_addr, wr_data});
    task automatic report_and_stop();
        $display("comparisons %0d, mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic check(input logic [11:0] exp, input logic [11:0] got);
        samples_checked++;
        if (got !== exp)
        begin
            $display("CHECK FAILED at %0t: expected %h, got %h", $time, exp, got);
            fail_count++;
        end
    endtask
    task automatic give_up();
        $display("CHECK FAILED at %0t: expected %h, got %h", $time, 1'b1, 1'b0);
        fail_count++;
        report_and_stop();
    endtask
    // request held from edge+2 until the edge that samples ready high
    task automatic xfer(input rtcis_op_type op, input logic [7:0] d, input logic last);
        int n;
        n = 0;
        @(posedge sys_clk);
        #2;
        cmd_valid = 1'b1;
        cmd_op = op;
        cmd_data = d;
        cmd_last = last;
        @(posedge sys_clk);
        while (cmd_ready !== 1'b1)
        begin
            n++;
            if (n > 2000)
                give_up();
            @(posedge sys_clk);
        end
        #2;
        cmd_valid = 1'b0;
        if (op == RTCIS_OP_WRITE || op == RTCIS_OP_READ)
        begin
            n = 0;
            while (rsp_valid !== 1'b1)
            begin
                n++;
                if (n > 2000)
                    give_up();
                @(posedge sys_clk);
                #1;
            end
            rd_v = rsp_data;
            nk_v = rsp_nack;
        end
    endtask
    task automatic st();
        xfer(RTCIS_OP_START, 8'h00, 1'b0);
    endtask
    task automatic sp();
        xfer(RTCIS_OP_STOP, 8'h00, 1'b0);
    endtask
    task automatic wr(input logic [7:0] b, input logic nk);
        xfer(RTCIS_OP_WRITE, b, 1'b0);
        check(12'(nk), 12'(nk_v));
    endtask
    task automatic rd(input logic last, input logic [7:0] exp);
        xfer(RTCIS_OP_READ, 8'h00, last);
        check(12'(exp), 12'(rd_v));
    endtask
    task automatic pop_chk(input logic [11:0] exp);
        check(exp, (wq.size() > 0) ? wq.pop_front() : 12'hxxx);
    endtask
    // slave link side needs about a microsecond after release before a start
    task automatic do_reset();
        @(posedge sys_clk);
        #2;
        rst_n = 1'b0;
        repeat (5) @(posedge sys_clk);
        #2;
        rst_n = 1'b1;
        repeat (25) @(posedge sys_clk);
    endtask
    initial
    begin
        do_reset();
        st();
        wr(8'ha2, 1'b0);
        wr(8'hf3, 1'b0);
        wr(8'ha5, 1'b0);
        wr(8'h5a, 1'b0);
        sp();
        pop_chk(12'h3a5);
        pop_chk(12'h45a);
        $display("test write done");
        st();
        wr(8'ha2, 1'b0);
        wr(8'hfe, 1'b0);
        wr(8'h11, 1'b0);
        wr(8'h22, 1'b0);
        wr(8'h33, 1'b0);
        sp();
        pop_chk(12'he11);
        pop_chk(12'hf22);
        pop_chk(12'h033);
        $display("test pointer wrap done");
        st();
        wr(8'ha2, 1'b0);
        wr(8'h0e, 1'b0);
        sp();
        check(12'h000, 12'(wq.size()));
        $display("test pointer only done");
        st();
        wr(8'ha3, 1'b0);
        rd(1'b0, 8'h11);
        rd(1'b0, 8'h22);
        rd(1'b1, 8'h33);
        sp();
        $display("test read from pointer done");
        st();
        wr(8'ha2, 1'b0);
        wr(8'h03, 1'b0);
        st();
        wr(8'ha3, 1'b0);
        rd(1'b0, 8'ha5);
        rd(1'b1, 8'h5a);
        sp();
        $display("test addressed read done");
        foreach (bad[i])
        begin
            st();
            wr(bad[i], 1'b1);
            wr(8'h77, 1'b1);
            sp();
        end
        check(12'h000, 12'(wq.size()));
        $display("test foreign address done");
        st();
        wr(8'ha2, 1'b0);
        wr(8'h05, 1'b0);
        do_reset();
        st();
        wr(8'ha3, 1'b0);
        rd(1'b0, 8'h00);
        rd(1'b1, 8'h00);
        sp();
        $display("test reset in mid transfer done");
        report_and_stop();
    end
endmodule
`default_nettype wire
